// ---- rtl/priority_interrupt_arbiter.sv ----
// priority interrupt arbiter with avalon-mm register slave
// Overview of operation
// R1: 64 sources, each gets one of four levels
// R2: fixed-priority sources ignore priority writes
// R3: within level, lowest source number wins
// R4: request core and supply service address
// R5: normal address is vector base plus vector
// R6: higher level is forwarded while servicing
// R7: core masks levels with two status bits
// R8: presented-level field encodes offered level
// R9: software defines fast interrupt at level 2
// R10: fast only on match and level 2
// R11: fast uses matching low/high address registers
// R12: two fast interrupts classified before core
// R13: core skips fast handling on subroutine jump
// R14: wake clock unit on request in low power
// R15: drive initial fetch address after reset
// R16: registers reachable as peripheral bus slave
// R17: wake only if enabled before low power
// R18: two-bit priority field, reset 00 disabled
// R19: highest active level is presented first
// R20: no pending request drops request, code 00
//
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
module priority_interrupt_arbiter #(
   parameter logic [63:0] FIXED_MASK = 64'h0000_0000_0000_0001,
   parameter logic [1:0] FIXED_CODE = 2'h3,
   parameter logic [63:0] LOWRANGE_MASK = 64'h0000_0000_0000_0000,
   parameter logic [20:0] RESET_ADDR = 21'h000000
) (
   input wire logic CLK,
   input wire logic RST,
   input wire irq_arb_pkg::avs_req_t AVS_REQ,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic [63:0] IRQ_SRC,
   input wire logic LOW_POWER,
   output irq_arb_pkg::core_out_t CORE,
   output logic WAKE
);
   import irq_arb_pkg::*;

   arb_state_t st; // registered state
   arb_state_t next_st; // next state
   logic [1:0] code [NSRC]; // effective priority code per source
   logic [1:0] lvl [NSRC]; // level 0..3 per source
   logic [NSRC-1:0] en_mask; // sources with nonzero priority
   logic [NSRC-1:0] pend; // enabled and requesting
   logic best_ok; // any winner
   logic [1:0] best_lvl; // winning level
   logic [VEC_W-1:0] best_i; // winning vector number
   logic hit0; // fast match 0
   logic hit1; // fast match 1
   logic busy; // bus request present
   logic [4:0] idx; // register index
   logic aligned; // low address bits zero
   logic [31:0] rd_mux; // read data selected
   logic [15:0] prio_word; // packed priority word for read

   // merge a 16-bit write under byte enables
   function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
      logic [15:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = d[7:0];
      end
      if (be[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   // effective code and level per source
   always_comb begin
      for (int i = 0; i < NSRC; i++) begin
         // fixed sources read their fixed code
         code[i] = FIXED_MASK[i] ? FIXED_CODE : st.prio[i]; // R2
         // low-range sources map codes 1..3 to levels 0..2
         lvl[i] = LOWRANGE_MASK[i] ? 2'(code[i] - 2'h1) : code[i]; // R1
         en_mask[i] = (code[i] != PRIO_OFF); // R18
         pend[i] = en_mask[i] & IRQ_SRC[i];
      end
   end

   // arbitration: scan down so equal level keeps lower number
   always_comb begin
      best_ok = 1'b0;
      best_lvl = 2'h0;
      best_i = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (pend[i] && (!best_ok || lvl[i] >= best_lvl)) begin // R3 R19
            best_ok = 1'b1;
            best_lvl = lvl[i];
            best_i = VEC_W'(i);
         end
      end
      // fast classification, match 0 takes precedence
      hit0 = best_ok && best_lvl == LVL_FAST && best_i == st.fm[0]; // R10 R12
      hit1 = best_ok && best_lvl == LVL_FAST && best_i == st.fm[1] && !hit0; // R10 R12
   end

   // bus decode
   assign busy = AVS_REQ.read | AVS_REQ.write;
   assign idx = AVS_REQ.address[6:2];
   assign aligned = (AVS_REQ.address[1:0] == 2'h0);
   // waitrequest drops one cycle after the request appears
   assign AVS_WAITREQUEST = busy & ~st.ack; // R16

   // read multiplexer
   always_comb begin
      rd_mux = 32'h0000_0000;
      prio_word = 16'h0000;
      for (int j = 0; j < 8; j++) begin
         prio_word[j*2 +: 2] = code[{idx[2:0], 3'(j)}];
      end
      if (aligned) begin
         if (idx <= IDX_PRIO7) begin
            rd_mux[15:0] = prio_word;
         end else if (idx >= IDX_PEND0 && idx <= IDX_PEND3) begin
            // pending view, sixteen sources per word
            rd_mux[15:0] = pend[(idx - IDX_PEND0) * 16 +: 16];
         end else begin
            unique case (idx)
               IDX_VBASE: rd_mux[15:0] = st.vbase;
               IDX_FM0: rd_mux[VEC_W-1:0] = st.fm[0];
               IDX_FAL0: rd_mux[15:0] = st.fal[0];
               IDX_FAH0: rd_mux[15:0] = st.fah[0];
               IDX_FM1: rd_mux[VEC_W-1:0] = st.fm[1];
               IDX_FAL1: rd_mux[15:0] = st.fal[1];
               IDX_FAH1: rd_mux[15:0] = st.fah[1];
               IDX_CTRL: begin
                  // presented level and request state
                  rd_mux[CTRL_LVL_LSB +: 2] = st.core.level; // R8
                  rd_mux[CTRL_REQ_BIT] = st.core.req;
                  rd_mux[CTRL_FAST_BIT] = st.core.fast;
               end
               default: rd_mux = 32'h0000_0000; // unmapped reads zero
            endcase
         end
      end
   end

   // next-state logic
   always_comb begin
      next_st = st;
      // bus handshake
      next_st.ack = busy & ~st.ack; // R16
      if (busy && !st.ack) begin
         next_st.rdata = rd_mux;
      end
      // write takes effect at the edge waitrequest is low
      if (AVS_REQ.write && st.ack && aligned) begin
         if (idx <= IDX_PRIO7) begin
            for (int j = 0; j < 8; j++) begin
               if (AVS_REQ.byteenable[j / 4] && !FIXED_MASK[{idx[2:0], 3'(j)}]) begin // R2
                  next_st.prio[{idx[2:0], 3'(j)}] = AVS_REQ.writedata[j*2 +: 2]; // R1
               end
            end
         end else begin
            unique case (idx)
               IDX_VBASE: next_st.vbase = wr16(st.vbase, AVS_REQ.writedata,
                                               AVS_REQ.byteenable);
               IDX_FM0: begin
                  if (AVS_REQ.byteenable[0]) begin
                     next_st.fm[0] = AVS_REQ.writedata[VEC_W-1:0];
                  end
               end
               IDX_FAL0: next_st.fal[0] = wr16(st.fal[0], AVS_REQ.writedata,
                                               AVS_REQ.byteenable);
               IDX_FAH0: next_st.fah[0] = wr16(st.fah[0], AVS_REQ.writedata,
                                               AVS_REQ.byteenable);
               IDX_FM1: begin
                  if (AVS_REQ.byteenable[0]) begin
                     next_st.fm[1] = AVS_REQ.writedata[VEC_W-1:0];
                  end
               end
               IDX_FAL1: next_st.fal[1] = wr16(st.fal[1], AVS_REQ.writedata,
                                               AVS_REQ.byteenable);
               IDX_FAH1: next_st.fah[1] = wr16(st.fah[1], AVS_REQ.writedata,
                                               AVS_REQ.byteenable);
               default: next_st.rdata = st.rdata; // read-only or unmapped: ignored
            endcase
         end
      end
      // low-power entry snapshots the enabled set
      next_st.lp_d = LOW_POWER;
      if (LOW_POWER && !st.lp_d) begin
         next_st.wake_en = en_mask; // R17
      end
      next_st.wake = LOW_POWER & |(IRQ_SRC & (st.lp_d ? st.wake_en : en_mask)); // R14 R17
      // core-facing outputs
      unique case (st.phase)
         ST_BOOT: begin
            // hold initial fetch address for one cycle
            next_st.phase = ST_RUN;
            next_st.core.addr_oe = 1'b0;
         end
         ST_RUN: begin
            // always present current best, so a higher level is nested
            next_st.core.req = best_ok; // R4 R6 R20
            next_st.core.vector = best_ok ? best_i : '0;
            next_st.core.fast = hit0 | hit1; // R12
            if (!best_ok) begin
               next_st.core.level = PL_NONE; // R20
            end else if (best_lvl == 2'h0) begin
               next_st.core.level = PL_L0; // R8
            end else if (best_lvl == 2'h1) begin
               next_st.core.level = PL_L1; // R8
            end else begin
               next_st.core.level = PL_L23; // R8
            end
            if (hit0) begin
               next_st.core.addr = {st.fah[0][4:0], st.fal[0]}; // R11
            end else if (hit1) begin
               next_st.core.addr = {st.fah[1][4:0], st.fal[1]}; // R11
            end else begin
               next_st.core.addr = {st.vbase[14:0], next_st.core.vector}; // R5
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         st.phase <= ST_BOOT;
         st.prio <= {NSRC{PRIO_RST}}; // R18
         st.vbase <= VBASE_RST;
         st.fm <= {2{FM_RST}};
         st.fal <= {2{FA_RST}};
         st.fah <= {2{FA_RST}};
         st.wake_en <= 64'h0000_0000_0000_0000;
         st.lp_d <= 1'b0;
         st.wake <= 1'b0;
         st.ack <= 1'b0;
         st.rdata <= 32'h0000_0000;
         st.core.req <= 1'b0;
         st.core.level <= PL_NONE;
         st.core.vector <= '0;
         st.core.fast <= 1'b0;
         st.core.addr <= RESET_ADDR; // R15
         st.core.addr_oe <= 1'b1; // R15
      end else begin
         st <= next_st;
      end
   end

   assign AVS_READDATA = st.rdata;
   assign CORE = st.core;
   assign WAKE = st.wake;

   // checks: sampled on the rising edge, silent while reset is high
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   // with no request the level field reads none and no fast flag is shown
   property p_idle_code;
      !CORE.req |-> CORE.level == PL_NONE && !CORE.fast;
   endproperty
   a_idle_code: assert property (p_idle_code) else $error("idle level not 00"); // R20

   // a raised request always carries one of the three level codes
   property p_req_level;
      CORE.req |-> CORE.level != PL_NONE;
   endproperty
   a_req_level: assert property (p_req_level) else $error("request with level 00"); // R8

   // the boot address stands one cycle with no request, then is withdrawn
   property p_boot_addr;
      CORE.addr_oe |-> CORE.addr == RESET_ADDR && !CORE.req ##1 !CORE.addr_oe;
   endproperty
   a_boot_addr: assert property (p_boot_addr) else $error("boot address wrong"); // R15

   // fast flag only for a level-2 winner that hits a match register;
   // the match registers are compared live, so software must not rewrite
   // one while its own fast source is being presented
   property p_fast_lvl;
      CORE.fast |-> CORE.req && CORE.level == PL_L23 &&
         (CORE.vector == st.fm[0] || CORE.vector == st.fm[1]);
   endproperty
   a_fast_lvl: assert property (p_fast_lvl) else $error("fast without level 2 match"); // R10

   // normal address is the base with the vector in the low bits;
   // the base is compared live, so it is meant to be set before sources run
   property p_norm_addr;
      CORE.req && !CORE.fast |-> CORE.addr == {st.vbase[14:0], CORE.vector};
   endproperty
   a_norm_addr: assert property (p_norm_addr) else $error("normal vector address wrong"); // R5

   // fast address on a match of register 0 comes from the low/high pair of register 0
   property p_fast_addr;
      CORE.fast && CORE.vector == st.fm[0] |-> CORE.addr == {st.fah[0][4:0], st.fal[0]};
   endproperty
   a_fast_addr: assert property (p_fast_addr) else $error("fast address wrong"); // R11

   // the winner was requesting at the edge that computed it
   property p_winner_src;
      CORE.req |-> |(($past(IRQ_SRC) >> CORE.vector) & 64'h1);
   endproperty
   a_winner_src: assert property (p_winner_src) else $error("winner was not requesting"); // R4

   // the winner held a nonzero priority code at that edge
   property p_win_en;
      CORE.req |-> |(($past(en_mask) >> CORE.vector) & 64'h1);
   endproperty
   a_win_en: assert property (p_win_en) else $error("disabled source won"); // R18

   // wake only in low power and only with a request present
   property p_wake_lp;
      WAKE |-> $past(LOW_POWER) && $past(|IRQ_SRC);
   endproperty
   a_wake_lp: assert property (p_wake_lp) else $error("wake outside low power"); // R14

   // in settled low power only sources enabled before entry may wake;
   // enabling a source after entry must not restart the clocks
   property p_wake_snap;
      WAKE && $past(st.lp_d) |-> |($past(IRQ_SRC) & $past(st.wake_en));
   endproperty
   a_wake_snap: assert property (p_wake_snap) else $error("wake from late-enabled source"); // R17

   // every request is answered in the cycle after it appears
   property p_bus_ack;
      busy && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("bus answer late"); // R16

   // a full write to the vector base lands at the accepting edge
   property p_vbase_wr;
      AVS_REQ.write && !AVS_WAITREQUEST && aligned && idx == IDX_VBASE &&
         AVS_REQ.byteenable[1:0] == 2'h3 |=> st.vbase == $past(AVS_REQ.writedata[15:0]);
   endproperty
   a_vbase_wr: assert property (p_vbase_wr) else $error("vector base write lost"); // R16

   // read data still stand in the cycle after the accepting edge
   property p_rd_hold;
      AVS_REQ.read && !AVS_WAITREQUEST |=> $stable(AVS_READDATA);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved early"); // R16

   // main scenarios
   c_fast: cover property (CORE.fast);
   c_wake: cover property (WAKE);
   c_nest: cover property (CORE.level == PL_L0 ##1 CORE.level == PL_L23);
   c_read: cover property (AVS_REQ.read && !AVS_WAITREQUEST);
   c_fast1: cover property (CORE.fast && CORE.vector == st.fm[1]);
endmodule // priority_interrupt_arbiter

// ---- rtl/irq_arb_pkg.sv ----
// constants, register indices and carrier types of the interrupt arbiter
package irq_arb_pkg;
   localparam int NSRC = 64;
   localparam int VEC_W = 6;
   localparam int VA_W = 21;
   localparam int AV_ADDR_W = 7;
   // register indices; byte address is four times the index
   localparam logic [4:0] IDX_PRIO0 = 5'h00;
   localparam logic [4:0] IDX_PRIO7 = 5'h07;
   localparam logic [4:0] IDX_VBASE = 5'h08;
   localparam logic [4:0] IDX_FM0 = 5'h09;
   localparam logic [4:0] IDX_FAL0 = 5'h0A;
   localparam logic [4:0] IDX_FAH0 = 5'h0B;
   localparam logic [4:0] IDX_FM1 = 5'h0C;
   localparam logic [4:0] IDX_FAL1 = 5'h0D;
   localparam logic [4:0] IDX_FAH1 = 5'h0E;
   localparam logic [4:0] IDX_PEND0 = 5'h0F;
   localparam logic [4:0] IDX_PEND3 = 5'h12;
   localparam logic [4:0] IDX_CTRL = 5'h13;
   // status register field positions
   localparam int CTRL_LVL_LSB = 0;
   localparam int CTRL_REQ_BIT = 2;
   localparam int CTRL_FAST_BIT = 3;
   // reset values
   localparam logic [1:0] PRIO_RST = 2'h0;
   localparam logic [15:0] VBASE_RST = 16'h0000;
   localparam logic [5:0] FM_RST = 6'h00;
   localparam logic [15:0] FA_RST = 16'h0000;
   // priority codes and presented-level codes
   localparam logic [1:0] PRIO_OFF = 2'h0;
   localparam logic [1:0] LVL_FAST = 2'h2;
   localparam logic [1:0] PL_NONE = 2'h0;
   localparam logic [1:0] PL_L0 = 2'h1;
   localparam logic [1:0] PL_L1 = 2'h2;
   localparam logic [1:0] PL_L23 = 2'h3;
   typedef enum logic [1:0] {ST_BOOT = 2'b01, ST_RUN = 2'b10} phase_t;
   typedef struct packed {
      logic read;
      logic write;
      logic [AV_ADDR_W-1:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } avs_req_t;
   typedef struct packed {
      logic req;
      logic [1:0] level;
      logic [VEC_W-1:0] vector;
      logic fast;
      logic [VA_W-1:0] addr;
      logic addr_oe;
   } core_out_t;
   typedef struct packed {
      phase_t phase;
      logic [NSRC-1:0][1:0] prio;
      logic [15:0] vbase;
      logic [1:0][VEC_W-1:0] fm;
      logic [1:0][15:0] fal;
      logic [1:0][15:0] fah;
      logic [NSRC-1:0] wake_en;
      logic lp_d;
      logic wake;
      logic ack;
      logic [31:0] rdata;
      core_out_t core;
   } arb_state_t;
endpackage

// ---- verif/core_model.sv ----
// behavioural core that masks presented levels and enters low power on command
`timescale 1ns/1ps
module core_model (
   input wire logic CLK,
   input wire logic RST,
   input wire irq_arb_pkg::core_out_t CORE,
   input wire logic [1:0] MASK,
   input wire logic SLEEP,
   input wire logic SUB_JUMP,
   output logic LOW_POWER,
   output logic TAKEN,
   output logic FAST_ENTRY
);
   import irq_arb_pkg::*;

   // code 11 stands for level 2 or 3, so under mask 11 it is treated as masked
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         LOW_POWER <= 1'b0;
         TAKEN <= 1'b0;
         FAST_ENTRY <= 1'b0;
      end else begin
         LOW_POWER <= SLEEP;
         TAKEN <= CORE.req && (CORE.level > MASK);
         // fast handling starts only when the fetched word is no subroutine jump
         FAST_ENTRY <= CORE.req && CORE.fast && !SUB_JUMP;
      end
   end
endmodule // core_model

// ---- verif/priority_interrupt_arbiter_test.sv ----
// self-checking testbench of the priority interrupt arbiter
`timescale 1ns/1ps
module priority_interrupt_arbiter_test;
   import irq_arb_pkg::*;
   logic clk;
   logic rst;
   avs_req_t req; // bus request driven by the bench
   logic [31:0] rdata;
   logic waitreq;
   logic [63:0] irq;
   logic sleep;
   logic [1:0] mask;
   logic low_power;
   logic taken;
   logic wake;
   logic sub_jump; // fetched word at the service address is a subroutine jump
   logic fast_entry; // core model entered fast handling
   core_out_t core;
   logic [1:0] shadow [64]; // bench copy of the priority codes
   logic [31:0] q; // last read data
   int n_errors;
   int total_checks;
   int cycles = 0;

   // source 40 uses the low range, so its codes mean levels 0..2
   priority_interrupt_arbiter #(.LOWRANGE_MASK(64'h0000_0100_0000_0000)) uut (
      .CLK(clk), .RST(rst), .AVS_REQ(req), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(waitreq), .IRQ_SRC(irq), .LOW_POWER(low_power),
      .CORE(core), .WAKE(wake));

   core_model partner (.CLK(clk), .RST(rst), .CORE(core), .MASK(mask),
      .SLEEP(sleep), .SUB_JUMP(sub_jump), .LOW_POWER(low_power), .TAKEN(taken),
      .FAST_ENTRY(fast_entry));

   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // cycle ceiling against a hang
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         n_errors = n_errors + 1;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one bus transfer; held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic wr, input logic [4:0] idx, input logic [31:0] d);
      req.read <= ~wr;
      req.write <= wr;
      req.address <= {idx, 2'b00};
      req.writedata <= d;
      req.byteenable <= 4'hF;
      @(posedge clk);
      while (waitreq !== 1'b0) @(posedge clk);
      q = rdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
      @(posedge clk);
   endtask

   // writes the whole priority word holding one source
   task automatic set_prio(input int src, input logic [1:0] code);
      logic [31:0] w;
      w = '0;
      shadow[src] = code;
      for (int j = 0; j < 8; j++) w[2*j +: 2] = shadow[(src / 8) * 8 + j];
      bus(1'b1, 5'(src / 8), w);
   endtask

   // lets the registered core outputs settle, then compares them
   task automatic core_is(input logic [1:0] lvl, input logic [5:0] vec, input logic fst);
      repeat (3) @(posedge clk);
      chk(32'({core.req, core.level, core.vector, core.fast}), 32'({|lvl, lvl, vec, fst}));
   endtask

   // main sequence
   initial begin
      rst = 1'b1;
      req = '0;
      irq = '0;
      sleep = 1'b0;
      sub_jump = 1'b0;
      mask = 2'h0;
      n_errors = 0;
      total_checks = 0;
      for (int i = 0; i < 64; i++) shadow[i] = PRIO_OFF;
      repeat (8) @(posedge clk);
      chk(32'({core.addr_oe, core.addr}), 32'({1'b1, 21'h000000}));
      rst <= 1'b0;
      core_is(PL_NONE, 6'h00, 1'b0);
      chk(32'(core.addr_oe), 32'h0);
      bus(1'b0, IDX_PRIO0, 32'h0);
      chk(q, 32'h3);
      bus(1'b1, IDX_VBASE, 32'h0ABC);
      bus(1'b0, IDX_VBASE, 32'h0);
      chk(q, 32'h0ABC);
      bus(1'b1, IDX_CTRL, 32'hF);
      bus(1'b0, IDX_CTRL, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 5'h14, 32'h0);
      chk(q, 32'h0);
      irq <= 64'h20;
      for (int c = 1; c < 4; c++) begin
         set_prio(5, 2'(c));
         core_is(c == 1 ? PL_L1 : PL_L23, 6'h05, 1'b0);
         chk(32'(core.addr), 32'({15'h0ABC, 6'h05}));
      end
      set_prio(5, PRIO_OFF);
      core_is(PL_NONE, 6'h00, 1'b0);
      irq <= 64'h0000_0100_0000_0000;
      for (int c = 1; c < 4; c++) begin
         set_prio(40, 2'(c));
         core_is(2'(c), 6'd40, 1'b0);
      end
      set_prio(40, PRIO_OFF);
      irq <= 64'h220;
      set_prio(9, 2'h1);
      set_prio(5, 2'h1);
      core_is(PL_L1, 6'h05, 1'b0);
      mask <= 2'h2;
      repeat (3) @(posedge clk);
      chk(32'(taken), 32'h0);
      set_prio(9, 2'h3);
      core_is(PL_L23, 6'h09, 1'b0);
      chk(32'(taken), 32'h1);
      set_prio(0, 2'h0);
      irq <= 64'h1;
      core_is(PL_L23, 6'h00, 1'b0);
      bus(1'b1, IDX_FM0, 32'h9);
      bus(1'b1, IDX_FAL0, 32'h1234);
      bus(1'b1, IDX_FAH0, 32'h0015);
      irq <= 64'h200;
      set_prio(9, 2'h2);
      core_is(PL_L23, 6'h09, 1'b1);
      chk(32'(core.addr), 32'h151234);
      chk(32'(fast_entry), 32'h1);
      set_prio(9, 2'h3);
      core_is(PL_L23, 6'h09, 1'b0);
      bus(1'b1, IDX_FM1, 32'hC);
      bus(1'b1, IDX_FAL1, 32'h5678);
      bus(1'b1, IDX_FAH1, 32'h001A);
      irq <= 64'h1000;
      sub_jump <= 1'b1;
      set_prio(12, 2'h2);
      core_is(PL_L23, 6'h0C, 1'b1);
      chk(32'(core.addr), 32'h1A5678);
      chk(32'(fast_entry), 32'h0);
      set_prio(12, PRIO_OFF);
      set_prio(9, PRIO_OFF);
      set_prio(5, 2'h1);
      irq <= 64'h0;
      sleep <= 1'b1;
      repeat (4) @(posedge clk);
      set_prio(12, 2'h1);
      irq <= 64'h1000;
      repeat (4) @(posedge clk);
      chk(32'(wake), 32'h0);
      irq <= 64'h20;
      repeat (4) @(posedge clk);
      chk(32'(wake), 32'h1);
      sleep <= 1'b0;
      irq <= 64'h0;
      repeat (4) @(posedge clk);
      chk(32'(wake), 32'h0);
      end_of_test();
   end
endmodule // priority_interrupt_arbiter_test
